/* pkg/synth_cfg_pkg.sv */
// Package: register layout, control codes and timing for the synthesizer configuration link
package synth_cfg_pkg;
    // Serial word
    localparam int WORD_BITS = 32;
    localparam logic [2:0] CODE_LOCK_PIN = 3'h5;
    localparam logic [2:0] CODE_EXT_CFG = 3'h6;
    localparam logic [2:0] CODE_STATUS = 3'h7;
    localparam logic [2:0] CODE_MAIN = 3'h0;
    // Lock pin configuration fields
    localparam int LP_SEL_LSB = 22;
    localparam int LP_FORCE_A = 19;
    localparam int LP_FORCE_B = 20;
    localparam logic [1:0] LP_SEL_RESET = 2'h1;
    localparam logic [1:0] LP_SEL_LOCK = 2'h1;
    localparam logic [1:0] LP_SEL_HIGH = 2'h3;
    // Extended configuration fields
    localparam int EX_LOCKED = 31;
    localparam int EX_SEARCH_DONE = 30;
    localparam int EX_FINE_LSB = 26;
    localparam int EX_BOOST_B = 25;
    localparam int EX_BOOST_A = 24;
    localparam int EX_ORDER_LSB = 22;
    localparam int EX_DGAIN = 21;
    localparam int EX_SHAPE = 20;
    localparam int EX_STRUCT_LSB = 18;
    localparam int EX_ACC_LSB = 16;
    localparam int EX_ZERO_BIT = 7;
    localparam int EX_DIVH_LSB = 3;
    // Writable bits of the extended register (status and reserved stay put)
    localparam logic [31:0] EX_WR_MASK = 32'h0fff0078;
    localparam logic [31:0] EX_RESET = 32'h00d40000;
    // Status register fields
    localparam int ST_LOSS_LOCK = 31;
    localparam int ST_RESELECT = 30;
    localparam int ST_SER_ERR = 29;
    localparam int ST_REV_LSB = 25;
    localparam int ST_PART_LSB = 21;
    localparam int ST_ADDR_LSB = 4;
    localparam int ST_READ = 3;
    localparam logic [31:0] ST_RW_MASK = 32'h001fff80;
    localparam logic [31:0] ST_RESET = 32'h00000080;
    // Band search accuracy codes
    localparam logic [1:0] ACC_ONE = 2'h0;
    localparam logic [1:0] ACC_TWO = 2'h1;
    localparam logic [1:0] ACC_FOUR = 2'h2;
    localparam int DIVH_WEIGHT = 256;
    // Host link clock: divide system clock by this half period count
    localparam logic [3:0] HOST_HALF_DIV = 4'h8;
endpackage

/* pkg/synth_link_if.sv */
// Interface: three-wire serial programming link plus readback line
`timescale 1ns/1ps
interface synth_link_if;
    logic sclk;
    logic sdata;
    logic cs_n;
    logic sdo;
    modport host (output sclk, output sdata, output cs_n, input sdo);
    modport device (input sclk, input sdata, input cs_n, output sdo);
endinterface

/* design/pin_sync.sv */
// Two-flop synchroniser for asynchronous single-bit inputs
`timescale 1ns/1ps
module pin_sync (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Data
    input wire logic async_in,
    output logic sync_out
);
    typedef struct packed {
        logic first;
        logic second;
    } sync_state_t;
    sync_state_t state;
    sync_state_t next_state;
    always_comb begin
        next_state.first = async_in;
        next_state.second = state.first;
        if (sys_rst_in) begin
            next_state = '0;
        end
    end
    always_ff @(posedge clk_in) begin
        state <= next_state;
    end
    assign sync_out = state.second;
endmodule // pin_sync

/* design/synth_cfg_device.sv */
// Device end: serial receiver and configuration register bank
`timescale 1ns/1ps
module synth_cfg_device
    import synth_cfg_pkg::*;
#(
    parameter logic [2:0] REVISION_CODE = 3'h2,   // Arbitrary value
    parameter logic [3:0] PART_CODE = 4'h9        // Arbitrary value
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Serial link
    synth_link_if.device link,
    // Loop status from analog side
    input wire logic loop_locked_in,
    input wire logic search_done_in,
    input wire logic search_restart_in,
    input wire logic base_precision_in,
    input wire logic [1:0] output_a_power_in,
    input wire logic [1:0] output_b_power_in,
    input wire logic [7:0] search_clock_divisor_low_in,
    // Configuration outputs
    output logic lock_pin_out,
    output logic [2:0] lock_window_code_out,
    output logic [2:0] output_a_level_out,
    output logic [2:0] output_b_level_out,
    output logic [1:0] modulator_order_out,
    output logic fraction_enable_out,
    output logic [2:0] dither_lsb_out,
    output logic dither_shaping_enable_out,
    output logic [1:0] modulator_structure_out,
    output logic [2:0] search_cycles_out,
    output logic [11:0] search_divisor_out,
    output logic main_write_out,
    output logic [31:0] main_word_out
);
    typedef struct packed {
        logic sclk_q;
        logic [5:0] count;
        logic [31:0] shift;
        logic [31:0] lock_pin_config;
        logic [31:0] extended_synth_config;
        logic [31:0] status_and_extension;
        logic [31:0] readback;
        logic read_active;
        logic sdo;
        logic locked_q;
        logic lock_pin;
        logic [2:0] window;
        logic [2:0] level_a;
        logic [2:0] level_b;
        logic [1:0] order;
        logic frac_en;
        logic [2:0] dither;
        logic shaping;
        logic [1:0] structure;
        logic [2:0] cycles;
        logic [11:0] divisor;
        logic main_write;
        logic [31:0] main_word;
    } dev_state_t;

    dev_state_t state;
    dev_state_t next_state;
    logic sclk_s;
    logic sdata_s;
    logic cs_n_s;
    logic locked_s;
    logic done_s;
    logic restart_s;

    // ****************************************
    // Input synchronisers
    // ****************************************
    pin_sync u_sync_sclk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .async_in(link.sclk), .sync_out(sclk_s));
    pin_sync u_sync_sdata (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .async_in(link.sdata), .sync_out(sdata_s));
    pin_sync u_sync_cs (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .async_in(link.cs_n), .sync_out(cs_n_s));
    pin_sync u_sync_lock (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .async_in(loop_locked_in), .sync_out(locked_s));
    pin_sync u_sync_done (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .async_in(search_done_in), .sync_out(done_s));
    pin_sync u_sync_restart (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .async_in(search_restart_in), .sync_out(restart_s));

    // ****************************************
    // Receiver, register bank and decode
    // ****************************************
    always_comb begin
        logic rise;
        logic fall;
        logic [31:0] word;
        logic [31:0] clr;
        rise = sclk_s && !state.sclk_q;
        fall = !sclk_s && state.sclk_q;
        word = state.shift;
        clr = '0;
        next_state = state;
        next_state.sclk_q = sclk_s;
        next_state.locked_q = locked_s;
        next_state.main_write = 1'b0;
        // Sticky flags: hardware set beats software clear in the same cycle
        if (!cs_n_s && rise) begin
            next_state.shift = {state.shift[30:0], sdata_s};
            if (state.count != 6'h3f) begin
                next_state.count = state.count + 6'h1;
            end
        end
        // Readback shifts out on falling edges, MSB first
        if (!cs_n_s && fall && state.read_active) begin
            next_state.sdo = state.readback[31];
            next_state.readback = {state.readback[30:0], 1'b0};
        end
        if (cs_n_s && !state.sclk_q && state.count == 6'h0) begin
            next_state.count = 6'h0;
        end
        // End of frame: load on chip-select release
        if (cs_n_s && state.count != 6'h0) begin
            next_state.count = 6'h0;
            next_state.read_active = 1'b0;
            next_state.sdo = 1'b0;
            if (state.count != 6'd32) begin
                next_state.status_and_extension[ST_SER_ERR] = 1'b1;
            end else begin
                unique case (word[2:0])
                    CODE_LOCK_PIN: next_state.lock_pin_config = word;
                    CODE_EXT_CFG: next_state.extended_synth_config =
                        (state.extended_synth_config & ~EX_WR_MASK)
                        | (word & EX_WR_MASK);
                    CODE_STATUS: begin
                        clr = word & 32'he0000000;
                        next_state.status_and_extension =
                            (state.status_and_extension & ~(ST_RW_MASK | clr))
                            | (word & ST_RW_MASK);
                        if (word[ST_READ]) begin
                            next_state.read_active = 1'b1;
                            unique case (word[ST_ADDR_LSB +: 3])
                                CODE_LOCK_PIN: next_state.readback = state.lock_pin_config;
                                CODE_EXT_CFG: next_state.readback = {state.locked_q,
                                    done_s, state.extended_synth_config[29:0]};
                                CODE_STATUS: next_state.readback = {state.status_and_extension[31:29],
                                    1'b0, REVISION_CODE, PART_CODE,
                                    state.status_and_extension[20:0]};
                                default: next_state.readback = '0;
                            endcase
                            // First bit must stand before the first rise of the next frame
                            next_state.sdo = next_state.readback[31];
                            next_state.readback = {next_state.readback[30:0], 1'b0};
                        end
                    end
                    default: begin
                        if (word[2:0] == CODE_MAIN) begin
                            next_state.main_write = 1'b1;
                            next_state.main_word = word;
                        end
                    end
                endcase
            end
        end
        // Readback request bit never holds a one
        next_state.status_and_extension[ST_READ] = 1'b0;
        if (state.locked_q && !locked_s) begin
            next_state.status_and_extension[ST_LOSS_LOCK] = 1'b1;
        end
        if (restart_s) begin
            next_state.status_and_extension[ST_RESELECT] = 1'b1;
        end
        // Live status bits
        next_state.extended_synth_config[EX_LOCKED] = locked_s;
        next_state.extended_synth_config[EX_SEARCH_DONE] = done_s;

        // Lock pin drive
        unique case (state.lock_pin_config[LP_SEL_LSB +: 2])
            LP_SEL_LOCK: next_state.lock_pin = locked_s;
            LP_SEL_HIGH: next_state.lock_pin = 1'b1;
            default: next_state.lock_pin = 1'b0;
        endcase
        // Window code: 0=10ns 1=6ns 2=3ns 4=4ns 5=4.5ns 6=1.5ns
        next_state.window = {state.extended_synth_config[EX_FINE_LSB +: 2],
            (state.extended_synth_config[EX_FINE_LSB +: 2] == 2'h2
             || state.extended_synth_config[EX_FINE_LSB +: 2] == 2'h0)
            ? base_precision_in : 1'b0};
        // Level index 0..7 = -4,-1,+2,+5,(boosted) +2,+5,+6,+7 dBm
        next_state.level_a = {state.extended_synth_config[EX_BOOST_A], output_a_power_in};
        next_state.level_b = {state.extended_synth_config[EX_BOOST_B], output_b_power_in};
        next_state.order = state.extended_synth_config[EX_ORDER_LSB +: 2];
        next_state.frac_en = (state.extended_synth_config[EX_ORDER_LSB +: 2] != 2'h0);
        next_state.dither = state.extended_synth_config[EX_DGAIN] ? 3'h4 : 3'h1;
        next_state.shaping = state.extended_synth_config[EX_SHAPE];
        next_state.structure = state.extended_synth_config[EX_STRUCT_LSB +: 2];
        unique case (state.extended_synth_config[EX_ACC_LSB +: 2])
            ACC_ONE: next_state.cycles = 3'h1;
            ACC_TWO: next_state.cycles = 3'h2;
            ACC_FOUR: next_state.cycles = 3'h4;
            default: next_state.cycles = 3'h1;
        endcase
        next_state.divisor = {state.extended_synth_config[EX_DIVH_LSB +: 4], 8'h00}
            + {4'h0, search_clock_divisor_low_in};
        if (sys_rst_in) begin
            next_state = '0;
            next_state.lock_pin_config[LP_SEL_LSB +: 2] = LP_SEL_RESET;
            next_state.extended_synth_config = EX_RESET;
            next_state.status_and_extension = ST_RESET;
            next_state.dither = 3'h1;
            next_state.cycles = 3'h1;
            next_state.sclk_q = 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        state <= next_state;
    end

    assign link.sdo = state.sdo;
    assign lock_pin_out = state.lock_pin;
    assign lock_window_code_out = state.window;
    assign output_a_level_out = state.level_a;
    assign output_b_level_out = state.level_b;
    assign modulator_order_out = state.order;
    assign fraction_enable_out = state.frac_en;
    assign dither_lsb_out = state.dither;
    assign dither_shaping_enable_out = state.shaping;
    assign modulator_structure_out = state.structure;
    assign search_cycles_out = state.cycles;
    assign search_divisor_out = state.divisor;
    assign main_write_out = state.main_write;
    assign main_word_out = state.main_word;
endmodule // synth_cfg_device

/* design/synth_cfg_host.sv */
// Host end: command registers driving 32-bit serial frames
`timescale 1ns/1ps
module synth_cfg_host
    import synth_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Register port
    input wire logic [1:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    // Serial link
    synth_link_if.host link
);
    // Offsets: 0 word to send (write starts frame), 1 status, 2 last readback
    typedef enum logic [1:0] {
        IDLE = 2'b00,
        SHIFT = 2'b01,
        GAP = 2'b10
    } host_fsm_t;
    typedef struct packed {
        host_fsm_t fsm;
        logic [31:0] shift;
        logic [31:0] rx;
        logic [5:0] bits;
        logic [3:0] div;
        logic sclk;
        logic cs_n;
        logic sdata;
        logic sdo_q;
        logic sdo_s;
        logic [31:0] rdata;
    } host_state_t;
    host_state_t state;
    host_state_t next_state;

    always_comb begin
        next_state = state;
        next_state.sdo_q = link.sdo;
        next_state.sdo_s = state.sdo_q;
        next_state.rdata = '0;
        if (rd_in) begin
            unique case (addr_in)
                2'h0: next_state.rdata = state.shift;
                2'h1: next_state.rdata = {31'h0, state.fsm != IDLE};
                2'h2: next_state.rdata = state.rx;
                default: next_state.rdata = '0;
            endcase
        end
        unique case (state.fsm)
            IDLE: begin
                if (wr_in && addr_in == 2'h0) begin
                    // Software supplies code bits and fixed ones
                    next_state.shift = wdata_in;
                    next_state.fsm = SHIFT;
                    next_state.cs_n = 1'b0;
                    next_state.bits = 6'h0;
                    next_state.div = 4'h0;
                    next_state.sdata = wdata_in[31];
                end
            end
            SHIFT: begin
                next_state.div = state.div + 4'h1;
                if (state.div == HOST_HALF_DIV - 4'h1) begin
                    next_state.div = 4'h0;
                    next_state.sclk = !state.sclk;
                    if (state.sclk) begin
                        next_state.shift = {state.shift[30:0], 1'b0};
                        next_state.sdata = state.shift[30];
                        if (state.bits == 6'd32) begin
                            next_state.fsm = GAP;
                        end
                    end else begin
                        next_state.bits = state.bits + 6'h1;
                        next_state.rx = {state.rx[30:0], state.sdo_s};
                    end
                end
            end
            GAP: begin
                next_state.cs_n = 1'b1;
                next_state.div = state.div + 4'h1;
                if (state.div == HOST_HALF_DIV - 4'h1) begin
                    next_state.fsm = IDLE;
                end
            end
            default: next_state.fsm = IDLE;
        endcase
        if (sys_rst_in) begin
            next_state = '0;
            next_state.cs_n = 1'b1;
            next_state.fsm = IDLE;
        end
    end
    always_ff @(posedge clk_in) begin
        state <= next_state;
    end
    assign link.sclk = state.sclk;
    assign link.cs_n = state.cs_n;
    assign link.sdata = state.sdata;
    assign rdata_out = state.rdata;
endmodule // synth_cfg_host

/* dv/synth_link_props.sv */
// Checker: timing and framing of the host-to-device serial link
`timescale 1ns/1ps
module synth_link_props (
    // Clock and reset
    input wire logic clk_in,
    input wire logic sys_rst_in,
    // Link wires
    input wire logic sclk,
    input wire logic sdata,
    input wire logic cs_n,
    input wire logic sdo
);
    // ****
    // Clock rises seen in the current frame
    // ****
    logic [6:0] rise_cnt;

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || cs_n) begin
            rise_cnt <= 7'h00;
        end else if ($rose(sclk)) begin
            rise_cnt <= rise_cnt + 7'h01;
        end
    end

    // ****
    // Properties
    // ****
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    sequence high_phase;
        sclk [*8] ##1 !sclk;
    endsequence

    sequence low_phase;
        !sclk [*8];
    endsequence

    // Bound on the whole frame, so a stuck host is seen
    sequence frame_close;
        ##[400:700] $rose(cs_n);
    endsequence

    frame_clock_count_a: assert property ($rose(cs_n) |-> rise_cnt == 7'h20)
        else $error("frame closed with a wrong clock count");
    idle_clock_low_a: assert property (cs_n |-> !sclk)
        else $error("serial clock high outside a frame");
    high_phase_len_a: assert property ($rose(sclk) |-> high_phase)
        else $error("serial clock high phase has the wrong length");
    low_phase_len_a: assert property ($fell(sclk) && !cs_n |-> low_phase)
        else $error("serial clock low phase too short");
    first_edge_gap_a: assert property ($fell(cs_n) |-> !sclk [*4])
        else $error("serial clock rose too soon after select");
    data_hold_high_a: assert property (!cs_n && sclk |-> $stable(sdata))
        else $error("serial data moved while clock high");
    frame_length_a: assert property ($fell(cs_n) |-> frame_close)
        else $error("frame did not close in time");
    readback_edge_a: assert property (!cs_n && $changed(sdo) |-> !sclk)
        else $error("readback line moved while clock high");
endmodule // synth_link_props

/* dv/synth_extended_config_regs_bench.sv */
// Bench: host and device joined over one link, a second device on a bench-driven link
`timescale 1ns/1ps
module synth_extended_config_regs_bench
    import synth_cfg_pkg::*;
;
    // ****
    // Signals and instances
    // ****
    logic clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [1:0] addr_in = 2'h0;
    logic [31:0] wdata_in = 32'h0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [31:0] rdata_out;
    logic lk = 1'b1;
    logic done = 1'b0;
    logic restart = 1'b0;
    logic base = 1'b0;
    logic [1:0] pa = 2'h0;
    logic [1:0] pb = 2'h0;
    logic [7:0] dlow = 8'h01;
    logic lock_pin, frac, shp, mw;
    logic [2:0] win, la, lb, dith, cyc;
    logic [1:0] ord, strc;
    logic [11:0] sdiv;
    logic [31:0] mword, seed, w, m, r, g, we, wm;
    logic rd_q = 1'b0;
    logic [31:0] exp_q[$];
    logic [31:0] msk_q[$];
    logic [31:0] main_q[$];
    int err_total = 0;
    int num_checks = 0;
    int nb[2] = '{31, 33};

    synth_link_if link_a ();
    synth_link_if link_b ();

    synth_cfg_host i_synth_cfg_host (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .link(link_a));

    synth_cfg_device i_synth_cfg_device (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .link(link_a),
        .loop_locked_in(lk), .search_done_in(done), .search_restart_in(restart),
        .base_precision_in(base), .output_a_power_in(pa), .output_b_power_in(pb),
        .search_clock_divisor_low_in(dlow), .lock_pin_out(lock_pin), .lock_window_code_out(win),
        .output_a_level_out(la), .output_b_level_out(lb), .modulator_order_out(ord),
        .fraction_enable_out(frac), .dither_lsb_out(dith), .dither_shaping_enable_out(shp),
        .modulator_structure_out(strc), .search_cycles_out(cyc), .search_divisor_out(sdiv),
        .main_write_out(mw), .main_word_out(mword));

    // Second device: the bench breaks the framing rules on this link
    synth_cfg_device i_synth_cfg_device_b (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
        .link(link_b), .loop_locked_in(lk), .search_done_in(done), .search_restart_in(restart),
        .base_precision_in(base), .output_a_power_in(pa), .output_b_power_in(pb),
        .search_clock_divisor_low_in(dlow), .lock_pin_out(), .lock_window_code_out(),
        .output_a_level_out(), .output_b_level_out(), .modulator_order_out(),
        .fraction_enable_out(), .dither_lsb_out(), .dither_shaping_enable_out(),
        .modulator_structure_out(), .search_cycles_out(), .search_divisor_out(),
        .main_write_out(), .main_word_out());

    synth_link_props u_props (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .sclk(link_a.sclk),
        .sdata(link_a.sdata), .cs_n(link_a.cs_n), .sdo(link_a.sdo));

    always #2.5 clk_in = ~clk_in;

    // ****
    // Tasks
    // ****
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] v);
        num_checks++;
        if (v !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, v);
        end
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic wr(input logic [1:0] a, input logic [31:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, input logic [31:0] e, input logic [31:0] k);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        exp_q.push_back(e);
        msk_q.push_back(k);
        @(posedge clk_in);
        rd_in <= 1'b0;
    endtask

    // Polling reads carry an empty mask, so only real results are compared
    task automatic send(input logic [31:0] d);
        logic busy;
        wr(2'h0, d);
        busy = 1'b1;
        for (int i = 0; i < 200 && busy !== 1'b0; i++) begin
            repeat (8) @(posedge clk_in);
            rd(2'h1, 32'h0, 32'h0);
            #1 busy = rdata_out[0];
        end
        repeat (10) @(posedge clk_in);
        #1;
    endtask

    // Link clock of 160 ns; data moves on the falling edge, readback taken on the rise
    task automatic frame2(input logic [31:0] d, input int n, output logic [31:0] got);
        got = 32'h0;
        @(posedge clk_in);
        link_b.cs_n <= 1'b0;
        for (int i = 0; i < n; i++) begin
            link_b.sdata <= d[31 - (i % 32)];
            repeat (16) @(posedge clk_in);
            link_b.sclk <= 1'b1;
            got = {got[30:0], link_b.sdo};
            repeat (16) @(posedge clk_in);
            link_b.sclk <= 1'b0;
        end
        repeat (16) @(posedge clk_in);
        link_b.cs_n <= 1'b1;
        link_b.sdata <= ~link_b.sdata;
        repeat (32) @(posedge clk_in);
    endtask

    task automatic rb2(input logic e);
        logic [31:0] v;
        frame2(32'h000000ff, 32, v);
        frame2(32'h00000087, 32, v);
        chk("serial_error", 32'(e), 32'(v[ST_SER_ERR]));
    endtask

    // ****
    // Result watcher and run
    // ****
    always @(posedge clk_in) begin
        if (rd_q) begin
            we = exp_q.pop_front();
            wm = msk_q.pop_front();
            chk("rdata", we & wm, rdata_out & wm);
        end
        if (mw === 1'b1) chk("main_word", main_q.pop_front(), mword);
        rd_q <= rd_in;
    end

    initial begin
        #500000;
        err_total++;
        complete_run();
    end

    initial begin
        seed = 32'h0000d255;
        link_b.cs_n = 1'b1;
        link_b.sclk = 1'b0;
        link_b.sdata = 1'b1;
        repeat (3) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        send(32'h000000ef);
        send(32'h00000087);
        rd(2'h2, EX_RESET | 32'h80000000, 32'hffffffff);
        for (int c = 0; c < 4; c++) begin
            send((32'(c) << LP_SEL_LSB) | 32'h00180005);
            for (int l = 0; l < 2; l++) begin
                @(posedge clk_in);
                lk <= l[0];
                repeat (10) @(posedge clk_in);
                #1;
                chk("lock_pin", 32'(c == 3 || (c == 1 && l == 1)), 32'(lock_pin));
            end
        end
        // Lock was lost above; pulse a band reselection, read flags, clear, read again
        @(posedge clk_in);
        restart <= 1'b1;
        repeat (4) @(posedge clk_in);
        restart <= 1'b0;
        for (int s = 0; s < 2; s++) begin
            send(32'h000000ff);
            send(32'h00000087 | {~s[0], ~s[0], ~s[0], 29'h0});
            rd(2'h2, {~s[0], ~s[0], 30'h0}, 32'he0000000);
        end
        for (int k = 0; k < 4; k++) begin
            w = xs();
            w[EX_ZERO_BIT] = 1'b0;
            w[2:0] = CODE_EXT_CFG;
            w[17:16] = 2'(k % 3);
            w[19:18] = 2'(k % 3 + 1);
            w[23:22] = 2'(k);
            r = xs();
            @(posedge clk_in);
            {pa, pb, dlow, base} <= r[12:0];
            done <= k[0];
            lk <= k[1];
            send(w);
            m = xs();
            m[2:0] = CODE_MAIN;
            main_q.push_back(m);
            send(m);
            chk("order", 32'(w[23:22]), 32'(ord));
            chk("fraction", 32'(w[23:22] != 2'h0), 32'(frac));
            chk("dither", w[21] ? 32'h4 : 32'h1, 32'(dith));
            chk("shaping", 32'(w[20]), 32'(shp));
            chk("structure", 32'(w[19:18]), 32'(strc));
            chk("cycles", 32'h1 << w[17:16], 32'(cyc));
            chk("divisor", 32'(dlow) + 32'(w[6:3]) * DIVH_WEIGHT, 32'(sdiv));
            chk("level_a", 32'({w[EX_BOOST_A], pa}), 32'(la));
            chk("level_b", 32'({w[EX_BOOST_B], pb}), 32'(lb));
            chk("window", 32'(w[27:26]), 32'(win[2:1]));
            chk("window_base", 32'((w[27:26] == 2'h0 || w[27:26] == 2'h2) && base), 32'(win[0]));
            send(32'h000000ef);
            send(32'h00000087);
            rd(2'h2, (w & EX_WR_MASK) | {k[1], k[0], 30'h0}, 32'hffffffff);
        end
        rb2(1'b0);
        for (int j = 0; j < 2; j++) begin
            frame2(32'h0, nb[j], g);
            rb2(1'b1);
            frame2(32'h20000087, 32, g);
            rb2(1'b0);
        end
        chk("main_left", 32'h0, 32'(main_q.size()));
        complete_run();
    end
endmodule // synth_extended_config_regs_bench
